// ==== rtl/aridg_pkg.sv ====
// Constants, types and CRC helpers of the ADC readout integrity guard
// Function
// - Channel results double buffered in two stages
// - Stage one loads on ready, linked all
// - Stage two freezes result at read start
// - Ready flags cleared when new results arrive
// - Checksum appended per sequence when enabled
// - Checksum is CRC-16, polynomial 0x8005
// - Width select adds two zero bytes
// - Checksum only at end of set
// - Key register resets to open value
// - Locked map ignores writes except key
// - Config CRC over 0x09-0x1F, fields masked
// - Config CRC only while locked, else cleared
// - Config CRC repeats every 14 converter clocks
// - Config checksum cleared by reset
// - First locked checksum becomes the reference
// - Mismatch with enable holds ready low
// - Unlock clears flag; reset starts unlocked
// - Ready pulse lasts half converter clock
// - Continuous read wraps to set start
package aridg_pkg;
    localparam int DATA_W = 24;
    localparam int CRC_W = 16;
    localparam int CTRL_BITS = 8;
    localparam logic [4:0] ADDR_MAP_FIRST = 5'h00;
    localparam logic [4:0] ADDR_CH_LAST = 5'h02;
    localparam logic [4:0] ADDR_CFG_FIRST = 5'h09;
    localparam logic [4:0] ADDR_STATUS = 5'h0a;
    localparam logic [4:0] ADDR_CFG_LAST = 5'h1e;
    localparam logic [4:0] ADDR_KEY = 5'h1f;
    localparam logic [7:0] KEY_OPEN = 8'ha5;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [23:0] STATUS_RESET = 24'h000028;
    localparam int ST_IRQ_EN = 0;
    localparam int ST_CRC_EN = 1;
    localparam int ST_CRC_WIDE = 2;
    localparam int ST_LINK = 3;
    localparam int ST_RDMODE_LO = 4;
    localparam int ST_FLAGS_LO = 16;
    localparam int CHK_LO = 8;
    localparam logic [1:0] RD_STATIC = 2'h0;
    localparam logic [1:0] RD_FULL = 2'h3;
    localparam int CLK_PER_CONVERTER_DIGITAL_CLOCK = 2;
    localparam int CFG_CRC_CONVERTER_DIGITAL_CLOCK = 14;
    localparam int CFG_CRC_CYCLES = CFG_CRC_CONVERTER_DIGITAL_CLOCK * CLK_PER_CONVERTER_DIGITAL_CLOCK;
    localparam int CFG_PAIRS = (int'(ADDR_KEY) - int'(ADDR_CFG_FIRST) + 2) / 2;

    // Serial engine phases
    typedef enum logic [2:0] {
        PH_CTRL = 3'b000,
        PH_DATA = 3'b001,
        PH_CRC = 3'b010,
        PH_PAD = 3'b011,
        PH_WRITE = 3'b100
    } aridg_phase_t;

    // One CRC step, message bit fed MSB first
    function automatic logic [15:0] aridg_crc_bit(input logic [15:0] c, input logic b);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
    endfunction

    // Whole word through the CRC, MSB first
    function automatic logic [15:0] aridg_crc_word(input logic [15:0] c, input logic [23:0] w);
        logic [15:0] r;
        r = c;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            r = aridg_crc_bit(r, w[i]);
        end
        return r;
    endfunction
endpackage

// ==== rtl/aridg_guard.sv ====
// Readout double buffer, serial checksum, map lock and configuration watchdog
`timescale 1ns/1ps
module aridg_guard
    import aridg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic sdi,
    input wire logic [23:0] adcData0,
    input wire logic [23:0] adcData1,
    input wire logic [23:0] adcData2,
    input wire logic [2:0] adcValid,
    output logic sdo,
    output logic sdoOe,
    output logic dataReadyN
);
    // Converter clock side
    logic [23:0] adcIn [3]; // Channel results in
    logic [23:0] stage1_r [3]; // First latch stage
    logic [2:0] flags_r, load; // Ready flags (low = new data), stage one loads
    logic [23:0] cfgMem_r [ADDR_CFG_FIRST:ADDR_CFG_LAST]; // Config map
    logic [7:0] key_r; // Write key
    logic [15:0] cfgChk_r, ref_r; // Published and reference config checksum
    logic [15:0] acc_r, accNxt; // Running config CRC and its next value
    logic refValid_r, irqFlag_r; // Reference held, config changed flag
    logic [4:0] crcCnt_r, lockAge_r; // Config CRC cycle counter, clocks since lock
    logic [5:0] idxA, idxB; // Words of the current pair
    logic [2:0] wrSync_r, rdSync_r; // Write and read-done toggle synchronisers
    logic wrEv, rdEv; // Write arrived, channel read finished
    logic [23:0] statusWord; // Status word as stored
    logic locked, irqEn, crcEn, crcWide, link; // Lock state and status controls
    logic [1:0] rdMode; // Continuous read grouping
    // Serial clock side
    aridg_phase_t phase_r; // Engine phase
    logic [4:0] bitCnt_r; // Bits moved in this word
    logic [23:0] sh_r; // Second latch stage and shifter
    logic [4:0] addr_r, wrAddr_r; // Address pointer, held write address
    logic [4:0] setFirst_r, setLast_r; // Bounds of the address set
    logic [15:0] crc_r; // Communication CRC
    logic [4:0] nxtAddr, rdSel; // Pointer after this word, address being loaded
    logic [23:0] rdWord; // Word at rdSel
    logic seqEnd, dataEnd; // Last address of set, all word bits shifted
    logic wrFire, rdFire, wrTgl_r, rdTgl_r; // Word written, channel read done, crossing toggles
    logic [23:0] wrData_r; // Held write data
    logic [1:0] rdChan_r; // Held finished channel
    assign adcIn[0] = adcData0;
    assign adcIn[1] = adcData1;
    assign adcIn[2] = adcData2;
    assign statusWord = cfgMem_r[ADDR_STATUS];
    assign irqEn = statusWord[ST_IRQ_EN];
    assign crcEn = statusWord[ST_CRC_EN];
    assign crcWide = statusWord[ST_CRC_WIDE];
    assign link = statusWord[ST_LINK];
    assign rdMode = statusWord[ST_RDMODE_LO +: 2];
    assign locked = key_r != KEY_OPEN;
    assign wrEv = wrSync_r[1] ^ wrSync_r[2];
    assign rdEv = rdSync_r[1] ^ rdSync_r[2];

    // Config word as the CRC engine sees it
    function automatic logic [23:0] cfgWordOf(input logic [5:0] idx);
        logic [23:0] w;
        w = 24'h000000;
        if (idx == 6'(ADDR_KEY)) begin
            w = {16'h0000, key_r}; // Checksum taken as zeros
        end else if (idx >= 6'(ADDR_CFG_FIRST) && idx <= 6'(ADDR_CFG_LAST)) begin
            w = cfgMem_r[idx[4:0]];
        end
        if (idx == 6'(ADDR_STATUS)) begin
            w[ST_FLAGS_LO +: 3] = 3'h7; // Ready flags taken as ones
        end
        return w;
    endfunction
    // Stage one and ready flags per channel
    generate
        for (genvar gi = 0; gi < 3; gi++) begin : gChan
            // Linked mode loads every channel together
            assign load[gi] = adcValid[gi] | (link & (|adcValid));
            // First latch on data ready
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1_r[gi] <= 24'h000000;
                end else if (load[gi]) begin
                    stage1_r[gi] <= adcIn[gi];
                end
            end
            // New data clears, finished read sets; new data wins
            always_ff @(posedge clk) begin
                if (rst) begin
                    flags_r[gi] <= 1'b1;
                end else if (load[gi]) begin
                    flags_r[gi] <= 1'b0;
                end else if (rdEv && rdChan_r == 2'(gi)) begin
                    flags_r[gi] <= 1'b1;
                end
            end
        end
    endgenerate
    // Ready pin: one clock low (half converter clock) or held by flag
    always_ff @(posedge clk) begin
        if (rst) begin
            dataReadyN <= 1'b1;
        end else begin
            dataReadyN <= ~((|load) | irqFlag_r);
        end
    end
    // Toggle synchronisers from the serial side
    always_ff @(posedge clk) begin
        if (rst) begin
            wrSync_r <= 3'h0;
            rdSync_r <= 3'h0;
        end else begin
            wrSync_r <= {wrSync_r[1:0], wrTgl_r};
            rdSync_r <= {rdSync_r[1:0], rdTgl_r};
        end
    end
    // Write key, always writable
    always_ff @(posedge clk) begin
        if (rst) begin
            key_r <= KEY_OPEN;
        end else if (wrEv && wrAddr_r == ADDR_KEY) begin
            key_r <= wrData_r[7:0];
        end
    end
    // Config map, writable only while open
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int a = int'(ADDR_CFG_FIRST); a <= int'(ADDR_CFG_LAST); a++) begin
                cfgMem_r[a] <= 24'h000000;
            end
            cfgMem_r[ADDR_STATUS] <= STATUS_RESET;
        end else if (wrEv && !locked && wrAddr_r >= ADDR_CFG_FIRST && wrAddr_r <= ADDR_CFG_LAST) begin
            cfgMem_r[wrAddr_r] <= wrData_r;
        end
    end
    // Two words of the map per clock
    always_comb begin
        idxA = 6'(ADDR_CFG_FIRST) + {crcCnt_r, 1'b0};
        idxB = idxA + 6'h01;
        accNxt = aridg_crc_word((crcCnt_r == 5'h00) ? 16'h0000 : acc_r, cfgWordOf(idxA));
        if (idxB <= 6'(ADDR_KEY)) begin
            accNxt = aridg_crc_word(accNxt, cfgWordOf(idxB));
        end
    end
    // Config CRC engine, reference and change flag
    always_ff @(posedge clk) begin
        if (rst || !locked) begin
            crcCnt_r <= 5'h00;
            lockAge_r <= 5'h00;
            acc_r <= 16'h0000;
            cfgChk_r <= 16'h0000;
            ref_r <= 16'h0000;
            refValid_r <= 1'b0;
            irqFlag_r <= 1'b0;
        end else begin
            crcCnt_r <= (crcCnt_r == 5'(CFG_CRC_CYCLES - 1)) ? 5'h00 : crcCnt_r + 5'h01;
            lockAge_r <= (lockAge_r == 5'h1f) ? lockAge_r : lockAge_r + 5'h01; // Saturates, no wrap
            if (crcCnt_r < 5'(CFG_PAIRS)) begin
                acc_r <= accNxt;
            end
            if (crcCnt_r == 5'(CFG_PAIRS)) begin
                cfgChk_r <= acc_r;
                if (!refValid_r) begin
                    ref_r <= acc_r;
                    refValid_r <= 1'b1;
                end else if (acc_r != ref_r && irqEn) begin
                    irqFlag_r <= 1'b1;
                end
            end
        end
    end
    // Serial side helpers
    assign seqEnd = addr_r == setLast_r;
    assign nxtAddr = seqEnd ? setFirst_r : addr_r + 5'h01;
    assign rdSel = (phase_r == PH_CTRL) ? sh_r[4:0] : nxtAddr;
    assign dataEnd = bitCnt_r == 5'(DATA_W);
    assign wrFire = phase_r == PH_WRITE && bitCnt_r == 5'(DATA_W - 1);
    assign rdFire = phase_r == PH_DATA && dataEnd && addr_r <= ADDR_CH_LAST;
    // Readback mux; sampled once at word start
    always_comb begin
        rdWord = cfgWordOf({1'b0, rdSel});
        if (rdSel == ADDR_KEY) begin
            rdWord[CHK_LO +: CRC_W] = cfgChk_r;
        end
        if (rdSel == ADDR_STATUS) begin
            rdWord[ST_FLAGS_LO +: 3] = flags_r;
        end
        if (rdSel <= ADDR_CH_LAST) begin
            rdWord = stage1_r[rdSel[1:0]];
        end
    end
    // Serial engine, cleared whenever the frame ends
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            phase_r <= PH_CTRL;
            bitCnt_r <= 5'h00;
            sh_r <= 24'h000000;
            addr_r <= 5'h00;
            setFirst_r <= 5'h00;
            setLast_r <= 5'h00;
            crc_r <= 16'h0000;
            sdo <= 1'b0;
            sdoOe <= 1'b0;
        end else begin
            case (phase_r)
                PH_CTRL: begin
                    sh_r <= {sh_r[22:0], sdi};
                    bitCnt_r <= bitCnt_r + 5'h01;
                    if (bitCnt_r == 5'(CTRL_BITS - 1)) begin
                        addr_r <= sh_r[4:0];
                        if (sdi) begin
                            // Read: freeze first word, open the output
                            phase_r <= PH_DATA;
                            sh_r <= rdWord;
                            sdo <= rdWord[23];
                            sdoOe <= 1'b1;
                            crc_r <= aridg_crc_bit(16'h0000, rdWord[23]);
                            bitCnt_r <= 5'h01;
                            setFirst_r <= (rdMode == RD_STATIC) ? sh_r[4:0] : ADDR_MAP_FIRST;
                            if (rdMode == RD_STATIC) begin
                                setLast_r <= sh_r[4:0];
                            end else if (rdMode == RD_FULL || sh_r[4:0] > ADDR_CH_LAST) begin
                                setLast_r <= ADDR_KEY;
                            end else begin
                                setLast_r <= ADDR_CH_LAST;
                            end
                        end else begin
                            phase_r <= PH_WRITE;
                            bitCnt_r <= 5'h00;
                        end
                    end
                end
                PH_DATA: begin
                    if (dataEnd && seqEnd && crcEn) begin
                        // End of set: checksum goes out
                        phase_r <= PH_CRC;
                        sh_r <= {crc_r, 8'h00};
                        sdo <= crc_r[15];
                        bitCnt_r <= 5'h01;
                    end else if (dataEnd) begin
                        // Next word; a new sequence restarts the CRC
                        addr_r <= nxtAddr;
                        sh_r <= rdWord;
                        sdo <= rdWord[23];
                        crc_r <= aridg_crc_bit(seqEnd ? 16'h0000 : crc_r, rdWord[23]);
                        bitCnt_r <= 5'h01;
                    end else begin
                        sdo <= sh_r[22];
                        sh_r <= {sh_r[22:0], 1'b0};
                        crc_r <= aridg_crc_bit(crc_r, sh_r[22]);
                        bitCnt_r <= bitCnt_r + 5'h01;
                    end
                end
                PH_CRC, PH_PAD: begin
                    if (bitCnt_r == 5'(CRC_W) && phase_r == PH_CRC && crcWide) begin
                        phase_r <= PH_PAD;
                        sdo <= 1'b0;
                        bitCnt_r <= 5'h01;
                    end else if (bitCnt_r == 5'(CRC_W)) begin
                        // Roll over to the start of the set
                        phase_r <= PH_DATA;
                        addr_r <= nxtAddr;
                        sh_r <= rdWord;
                        sdo <= rdWord[23];
                        crc_r <= aridg_crc_bit(16'h0000, rdWord[23]);
                        bitCnt_r <= 5'h01;
                    end else begin
                        sdo <= (phase_r == PH_CRC) ? sh_r[22] : 1'b0;
                        sh_r <= {sh_r[22:0], 1'b0};
                        bitCnt_r <= bitCnt_r + 5'h01;
                    end
                end
                PH_WRITE: begin
                    sh_r <= {sh_r[22:0], sdi};
                    bitCnt_r <= wrFire ? 5'h00 : bitCnt_r + 5'h01;
                    if (wrFire) begin
                        addr_r <= (addr_r == ADDR_KEY) ? ADDR_CFG_FIRST : addr_r + 5'h01;
                    end
                end
                default: begin
                    phase_r <= PH_CTRL;
                end
            endcase
        end
    end
    // Held write and read-done events toward the converter side
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            wrTgl_r <= 1'b0;
            rdTgl_r <= 1'b0;
            wrAddr_r <= 5'h00;
            wrData_r <= 24'h000000;
            rdChan_r <= 2'h0;
        end else begin
            if (wrFire) begin
                wrData_r <= {sh_r[22:0], sdi};
                wrAddr_r <= addr_r;
                wrTgl_r <= ~wrTgl_r;
            end
            if (rdFire) begin
                rdChan_r <= addr_r[1:0];
                rdTgl_r <= ~rdTgl_r;
            end
        end
    end
    // Checks on the converter side
    stage_load_a: assert property (@(posedge clk) disable iff (rst)
        adcValid[0] |=> stage1_r[0] == $past(adcData0)) else $error("stage one missed ch0");
    link_load_a: assert property (@(posedge clk) disable iff (rst)
        (link && adcValid == 3'h1) |=> stage1_r[2] == $past(adcData2)) else $error("link load missed");
    unlinked_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!link && adcValid == 3'h1) |=> $stable(stage1_r[1])) else $error("unlinked ch1 moved");
    flag_clear_a: assert property (@(posedge clk) disable iff (rst)
        adcValid[1] |=> !flags_r[1]) else $error("ready flag not cleared");
    ready_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (|adcValid) ##1 (adcValid == 3'h0 && !irqFlag_r) |-> !dataReadyN ##1 dataReadyN)
        else $error("ready pulse width wrong");
    unlock_clear_a: assert property (@(posedge clk) disable iff (rst)
        !locked |=> (cfgChk_r == 16'h0000 && !irqFlag_r)) else $error("unlocked state not clear");
    key_guard_a: assert property (@(posedge clk) disable iff (rst)
        (wrEv && locked && wrAddr_r == ADDR_STATUS) |=> $stable(statusWord)) else $error("locked write took");
    crc_period_a: assert property (@(posedge clk) disable iff (rst)
        lockAge_r == 5'(CFG_PAIRS + 1) |-> refValid_r && cfgChk_r == ref_r) else $error("reference late");
    irq_set_a: assert property (@(posedge clk) disable iff (rst)
        (locked && crcCnt_r == 5'(CFG_PAIRS) && refValid_r && acc_r != ref_r && irqEn)
        |=> irqFlag_r ##1 !dataReadyN) else $error("change flag not raised");
    // Checks on the serial side
    crc_word_a: assert property (@(posedge sck) disable iff (csN)
        (phase_r == PH_DATA && dataEnd && seqEnd && crcEn) |=> (phase_r == PH_CRC && sdo == $past(crc_r[15])))
        else $error("checksum not sent");
    pad_zero_a: assert property (@(posedge sck) disable iff (csN)
        (phase_r == PH_CRC && bitCnt_r == 5'h10 && crcWide) |=> (phase_r == PH_PAD && !sdo))
        else $error("pad bytes missing");
    irq_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(irqFlag_r));
    link_seen_c: cover property (@(posedge clk) disable iff (rst) link && adcValid == 3'h7);
    pad_seen_c: cover property (@(posedge sck) disable iff (csN) phase_r == PH_PAD);
endmodule // aridg_guard

// ==== dv/aridg_spi_host.sv ====
// Serial host model that frames control bytes and data words into the guard
`timescale 1ns/1ps
module aridg_spi_host (
    output logic sck,
    output logic csN,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdoOe
);
    // Clock stands still and frame is deselected between transfers
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    // One frame: control byte, then n whole bits; sdo caught at falling edges 8 to 7+n
    task automatic xfer(input logic [7:0] ctrl, input int n, input logic [127:0] wd,
                        output logic [127:0] rd, output logic oeOk);
        logic [7:0] c;
        c = ctrl;
        rd = '0;
        oeOk = 1'b1;
        #3 csN = 1'b0;
        sdi = c[7];
        for (int e = 1; e <= 8 + n; e++) begin
            #7.5 sck = 1'b1;
            #7.5 sck = 1'b0;
            // Every bit of a word is shifted before the frame may end
            if (e >= 8 && e < 8 + n) begin
                rd = {rd[126:0], sdo};
                oeOk = oeOk & (sdoOe === ctrl[0]);
            end
            c = {c[6:0], 1'b0};
            sdi = (e < 8) ? c[7] : wd[127];
            if (e >= 8) begin
                wd = {wd[126:0], 1'b0};
            end
        end
        #7.5 csN = 1'b1;
        // Released line shows the inverse of its last value
        sdi = ~sdi;
    endtask
endmodule // aridg_spi_host

// ==== dv/test_adc_readout_integrity_guard.sv ====
// Self-checking bench of the readout integrity guard with a reference model
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module test_adc_readout_integrity_guard;
    import aridg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic sck, csN, sdi, sdo, sdoOe, dataReadyN;
    logic [23:0] adcData0 = '0, adcData1 = '0, adcData2 = '0;
    logic [2:0] adcValid = '0;
    int num_errors = 0;
    int num_checks = 0;
    int drLow = 0; // Count of low ready samples
    logic [31:0] seed = 32'hccee; // Xorshift state
    logic [23:0] ch [3]; // Stage one model
    logic [23:0] cfg [9:30]; // Configuration model 0x09..0x1e
    logic [7:0] key = 8'ha5; // Key model
    logic [2:0] flags = 3'b111; // Ready flag model

    always #5 clk = ~clk;
    // Ready pin low samples
    always @(negedge clk) if (dataReadyN === 1'b0) drLow++;

    aridg_guard i_aridg_guard (.clk(clk), .rst(rst), .sck(sck), .csN(csN), .sdi(sdi),
        .adcData0(adcData0), .adcData1(adcData1), .adcData2(adcData2), .adcValid(adcValid),
        .sdo(sdo), .sdoOe(sdoOe), .dataReadyN(dataReadyN));
    aridg_spi_host i_aridg_spi_host (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));

    // Xorshift step
    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[23:0];
    endfunction

    // Bitwise CRC over the n low bits, MSB first
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [127:0] m, input int n);
        for (int i = n - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction

    // Expected configuration checksum, flags as ones
    function automatic logic [15:0] ccrc();
        logic [15:0] c;
        c = '0;
        for (int a = 9; a < 31; a++)
            c = crc(c, {104'h0, (a == 10) ? cfg[a] | 24'h070000 : cfg[a]}, 24);
        return crc(c, {120'h0, key}, 24);
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One frame plus settling time for the write crossing
    task automatic frm(input logic [7:0] ct, input int n, input logic [127:0] wd, output logic [127:0] r);
        logic ok;
        i_aridg_spi_host.xfer(ct, n, wd, r, ok);
        `CHK("sdo enable", 1'b1, ok)
        repeat (10) @(negedge clk);
    endtask

    task automatic rdw(input logic [4:0] a, output logic [23:0] v);
        logic [127:0] r;
        frm({2'b00, a, 1'b1}, 24, '1, r);
        v = r[23:0];
    endtask

    // Write with the lock model applied
    task automatic wrw(input logic [4:0] a, input logic [23:0] v);
        logic [127:0] r;
        frm({2'b00, a, 1'b0}, 24, {v, 104'h0}, r);
        if (a == 5'h1f) key = v[7:0];
        else if (key == 8'ha5) cfg[a] = v;
    endtask

    // Hang guard
    initial begin
        #500us;
        num_errors++;
        $display("[ERR] run exp done got hang");
        stop_test();
    end

    initial begin
        logic [127:0] r, e;
        logic [23:0] v;
        logic [15:0] cc;
        logic [2:0] ld;
        int n, lows;
        #1 rst = 1'b1; // A real rising edge, so the serial-side holders clear too
        for (int a = 9; a < 31; a++) cfg[a] = '0;
        cfg[10] = STATUS_RESET;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        `CHK("ready idle", 1'b1, dataReadyN)
        `CHK("sdo idle", 2'b00, {sdo, sdoOe})
        rdw(5'h0a, v);
        `CHK("status reset", cfg[10] | 24'h070000, v)
        rdw(5'h1f, v);
        `CHK("key reset", 24'h0000a5, v)
        $display("test reset done");
        // Link on/off, checksum off/16/32, single and all channels
        for (int m = 0; m < 4; m++) begin
            wrw(5'h0a, 24'h10 | (m[0] ? 24'h0 : 24'h8) | (m == 2 ? 24'h0 : 24'h2) | (m == 1 ? 24'h4 : 24'h0));
            @(negedge clk);
            adcData0 = rnd();
            adcData1 = rnd();
            adcData2 = rnd();
            adcValid = (m == 3) ? 3'b111 : 3'b001 << m;
            ld = cfg[10][3] ? 3'b111 : adcValid;
            if (ld[0]) ch[0] = adcData0;
            if (ld[1]) ch[1] = adcData1;
            if (ld[2]) ch[2] = adcData2;
            flags &= ~ld;
            @(negedge clk);
            adcValid = '0;
            for (int i = 0; i < 4; i++) if (dataReadyN !== 1'b0) @(negedge clk);
            `CHK("ready pulse", 1'b0, dataReadyN)
            @(negedge clk);
            `CHK("ready width", 1'b1, dataReadyN)
            repeat (4) @(negedge clk);
            rdw(5'h0a, v);
            `CHK("ready flags", cfg[10] | {5'h0, flags, 16'h0}, v)
            n = 96 + (cfg[10][1] ? (cfg[10][2] ? 32 : 16) : 0);
            frm(8'h01, n, '1, r);
            e = {56'h0, ch[0], ch[1], ch[2]};
            cc = crc(16'h0, e, 72);
            if (cfg[10][1]) e = {e[111:0], cc};
            if (cfg[10][2]) e = e << 16;
            e = {e[103:0], ch[0]};
            `CHK("read set", e, r)
            if (cfg[10][1]) `CHK("host crc", 16'h0, crc(16'h0, r >> (n - 88), 88))
            flags = 3'b111;
            $display("test readout %0d done", m);
        end
        // Lock, then watch the configuration checksum
        wrw(5'h0b, rnd());
        wrw(5'h0a, 24'h21);
        lows = drLow;
        wrw(5'h1f, 24'h0);
        repeat (40) @(negedge clk);
        wrw(5'h0b, rnd());
        rdw(5'h0b, v);
        `CHK("locked write", cfg[11], v)
        wrw(5'h0a, rnd());
        rdw(5'h0a, v);
        `CHK("locked status", cfg[10] | {5'h0, flags, 16'h0}, v)
        rdw(5'h1f, v);
        `CHK("config crc", {ccrc(), 8'h00}, v)
        repeat (30) @(negedge clk);
        rdw(5'h1f, v);
        `CHK("crc repeat", {ccrc(), 8'h00}, v)
        `CHK("no alarm", lows, drLow)
        wrw(5'h1f, 24'ha5);
        rdw(5'h1f, v);
        `CHK("unlocked crc", 24'h0000a5, v)
        wrw(5'h0b, rnd());
        rdw(5'h0b, v);
        `CHK("open write", cfg[11], v)
        $display("test lock done");
        stop_test();
    end
endmodule // test_adc_readout_integrity_guard
